/* sbp_pkg.sv */
package sbp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DATA_PINS = 8'h00;
  localparam logic [7:0] OFS_DATA_LAT = 8'h04;
  localparam logic [7:0] OFS_DATA_DIR = 8'h08;
  localparam logic [7:0] OFS_CTRL_PINS = 8'h0c;
  localparam logic [7:0] OFS_CTRL_LAT = 8'h10;
  localparam logic [7:0] OFS_CTRL_DIR = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_IRQ_PRIO = 8'h24;
  localparam logic [7:0] OFS_ANALOG = 8'h28;
  // field positions
  localparam int BIT_IN_BUFFER_OVERFLOW = 5;
  localparam int BIT_MODE = 4;
  localparam int BIT_PSP_IRQ = 7;
  localparam int CTRL_RD = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_CS = 2;
  // reset values
  localparam logic [7:0] RST_DATA_LAT = 8'h00;
  localparam logic [7:0] RST_DATA_DIR = 8'hff;
  localparam logic [2:0] RST_CTRL_LAT = 3'h0;
  localparam logic [2:0] RST_CTRL_DIR = 3'h7;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_IRQ_PRIO = 8'h7f;
  localparam logic [2:0] RST_ANALOG = 3'h0;
  localparam logic [2:0] ANALOG_DIGITAL = 3'h7;
  localparam logic [10:0] RST_SYNC = 11'h700;
  // synchronised pin bundle
  typedef struct packed {
    logic [2:0] ctrl;
    logic [7:0] data;
  } sbp_pins_t;
  // control and status layout
  typedef struct packed {
    logic in_buffer_full;
    logic out_buffer_full;
    logic in_buffer_overflow;
    logic slave_port_mode_sel;
    logic [3:0] rsvd;
  } sbp_stat_t;
endpackage : sbp_pkg

/* sbp_sync.sv */
module sbp_sync
#(
  parameter int W = 11,
  parameter logic [W-1:0] RST = '0
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // async in, filtered out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic out_ff;
      // three stage flops plus an output flop, change taken when stages two and three agree
      always_ff @(posedge i_ref_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          s1_ff <= RST[g];
          s2_ff <= RST[g];
          s3_ff <= RST[g];
          out_ff <= RST[g];
        end
        else
        begin
          s1_ff <= i_async[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff)
            out_ff <= s3_ff;
        end
      end
      assign o_sync[g] = out_ff;
    end
  endgenerate
endmodule : sbp_sync

/* sbp_port.sv */
// Local design decisions: the Wishbone slave port and the register offsets.
module sbp_port
  import sbp_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // device memory mode
  input wire logic i_micro_mode,
  // data port pins
  input wire logic [7:0] i_data_pin,
  output logic [7:0] o_data_pin,
  output logic [7:0] o_data_oe,
  // control port pins
  input wire logic [2:0] i_ctrl_pin,
  output logic [2:0] o_ctrl_pin,
  output logic [2:0] o_ctrl_oe,
  // interrupt
  output logic o_irq,
  output logic o_irq_prio
);
  sbp_pins_t pins_s;
  sbp_stat_t stat_rd;

  logic ack_ff;
  logic [7:0] rdat_ff;
  logic [7:0] out_latch_ff;
  logic [7:0] data_dir_ff;
  logic [2:0] ctrl_latch_ff;
  logic [2:0] ctrl_dir_ff;
  logic [2:0] analog_cfg_ff;
  logic [7:0] in_buf_ff;
  logic ibf_ff;
  logic obf_ff;
  logic in_buffer_overflow_ff;
  logic mode_ff;
  logic irq_flag_ff;
  logic [7:0] irq_en_ff;
  logic [7:0] irq_prio_ff;
  logic rd_act_ff;
  logic wr_act_ff;

  logic nxt_ibf;
  logic nxt_obf;
  logic nxt_in_buffer_overflow;
  logic nxt_irq_flag;
  logic [7:0] nxt_in_buf;

  // async pin capture
  // strobe and data pin synchroniser
  sbp_sync
  #(
    .W(11),
    .RST(RST_SYNC)
  )
  u_sync
  (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_ctrl_pin, i_data_pin}),
    .o_sync(pins_s)
  );

  // bus decode
  wire req = i_wb_cyc & i_wb_stb;
  wire wr_en = req & i_wb_we & ack_ff & i_wb_sel[0];
  wire rd_en = req & ~i_wb_we & ack_ff;
  wire [7:0] adr = i_wb_adr[7:0];
  wire [7:0] wdat = i_wb_dat[7:0];
  wire s_dpin = (adr == OFS_DATA_PINS);
  wire s_dlat = (adr == OFS_DATA_LAT);
  wire s_ddir = (adr == OFS_DATA_DIR);
  wire s_cpin = (adr == OFS_CTRL_PINS);
  wire s_clat = (adr == OFS_CTRL_LAT);
  wire s_cdir = (adr == OFS_CTRL_DIR);
  wire s_stat = (adr == OFS_STATUS);
  wire s_iflg = (adr == OFS_IRQ_FLAGS);
  wire s_ien = (adr == OFS_IRQ_EN);
  wire s_ipri = (adr == OFS_IRQ_PRIO);
  wire s_anlg = (adr == OFS_ANALOG);

  // mode gating
  // slave port gating
  wire psp_on = mode_ff & i_micro_mode;
  wire ctrl_digital = (analog_cfg_ff == ANALOG_DIGITAL);

  wire rd_act = psp_on & ~pins_s.ctrl[CTRL_CS] & ~pins_s.ctrl[CTRL_RD];
  wire wr_act = psp_on & ~pins_s.ctrl[CTRL_CS] & ~pins_s.ctrl[CTRL_WR];
  wire wr_start = wr_act & ~wr_act_ff;
  wire wr_end = ~wr_act & wr_act_ff;
  wire rd_start = rd_act & ~rd_act_ff;
  wire rd_end = ~rd_act & rd_act_ff;

  // cpu accesses with side effects
  wire cpu_rd_data = rd_en & s_dpin & psp_on;
  wire cpu_wr_data = wr_en & s_dpin & psp_on;
  wire wr_lat = wr_en & (s_dpin | s_dlat);
  wire wr_stat = wr_en & s_stat;
  wire wr_flags = wr_en & s_iflg;

  // flag next values, set wins over clear
  // input full tracking
  assign nxt_ibf = wr_start | (ibf_ff & ~cpu_rd_data);
  assign nxt_in_buffer_overflow = (wr_start & ibf_ff & ~cpu_rd_data) |
                    (in_buffer_overflow_ff & ~(wr_stat & ~wdat[BIT_IN_BUFFER_OVERFLOW]));
  assign nxt_obf = cpu_wr_data | (obf_ff & ~rd_end);
  assign nxt_irq_flag = (rd_end | wr_end) |
                        (irq_flag_ff & ~(wr_flags & wdat[BIT_PSP_IRQ]));
  assign nxt_in_buf = wr_start ? pins_s.data : in_buf_ff;

  // read view
  // status layout
  assign stat_rd = '{
    in_buffer_full: ibf_ff,
    out_buffer_full: obf_ff,
    in_buffer_overflow: in_buffer_overflow_ff,
    slave_port_mode_sel: mode_ff,
    rsvd: 4'h0
  };
  wire [7:0] dpin_rd = psp_on ? in_buf_ff : pins_s.data;
  wire [7:0] cpin_rd = ctrl_digital ? {5'h00, pins_s.ctrl} : 8'h00;
  wire [7:0] flags_rd = {irq_flag_ff, 7'h00};
  wire [7:0] rd_mux = ({8{s_dpin}} & dpin_rd) |
                      ({8{s_dlat}} & out_latch_ff) |
                      ({8{s_ddir}} & data_dir_ff) |
                      ({8{s_cpin}} & cpin_rd) |
                      ({8{s_clat}} & {5'h00, ctrl_latch_ff}) |
                      ({8{s_cdir}} & {5'h00, ctrl_dir_ff}) |
                      ({8{s_stat}} & stat_rd) |
                      ({8{s_iflg}} & flags_rd) |
                      ({8{s_ien}} & irq_en_ff) |
                      ({8{s_ipri}} & irq_prio_ff) |
                      ({8{s_anlg}} & {5'h00, analog_cfg_ff});

  // bus answer, one wait cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 8'h00;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff)
        rdat_ff <= rd_mux;
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = {24'h000000, rdat_ff};

  // data port registers
  // latch write
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      out_latch_ff <= RST_DATA_LAT;
      data_dir_ff <= RST_DATA_DIR;
    end
    else
    begin
      if (wr_lat)
        out_latch_ff <= wdat;
      if (wr_en & s_ddir)
        data_dir_ff <= wdat;
    end
  end

  // control port registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctrl_latch_ff <= RST_CTRL_LAT;
      ctrl_dir_ff <= RST_CTRL_DIR;
      analog_cfg_ff <= RST_ANALOG;
    end
    else
    begin
      if (wr_en & (s_cpin | s_clat))
        ctrl_latch_ff <= wdat[2:0];
      if (wr_en & s_cdir)
        ctrl_dir_ff <= wdat[2:0];
      if (wr_en & s_anlg)
        analog_cfg_ff <= wdat[2:0];
    end
  end

  // slave port status
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ibf_ff <= 1'b0;
      obf_ff <= 1'b0;
      in_buffer_overflow_ff <= 1'b0;
      mode_ff <= 1'b0;
      in_buf_ff <= 8'h00;
    end
    else
    begin
      ibf_ff <= nxt_ibf;
      obf_ff <= nxt_obf;
      in_buffer_overflow_ff <= nxt_in_buffer_overflow;
      in_buf_ff <= nxt_in_buf;
      if (wr_stat)
        mode_ff <= wdat[BIT_MODE];
    end
  end

  // strobe history
  // async access tracking
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rd_act_ff <= 1'b0;
      wr_act_ff <= 1'b0;
    end
    else
    begin
      rd_act_ff <= rd_act;
      wr_act_ff <= wr_act;
    end
  end

  // interrupt registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      irq_flag_ff <= 1'b0;
      irq_en_ff <= RST_IRQ_EN;
      irq_prio_ff <= RST_IRQ_PRIO;
    end
    else
    begin
      irq_flag_ff <= nxt_irq_flag;
      if (wr_en & s_ien)
        irq_en_ff <= wdat;
      if (wr_en & s_ipri)
        irq_prio_ff <= wdat;
    end
  end

  assign o_irq = irq_flag_ff & irq_en_ff[BIT_PSP_IRQ] & i_micro_mode;
  assign o_irq_prio = irq_prio_ff[BIT_PSP_IRQ];

  // pin drivers
  // in slave port mode, drive latch during read only; otherwise per direction register
  assign o_data_oe = psp_on ? {8{rd_act_ff}} : ~data_dir_ff;
  assign o_data_pin = out_latch_ff;
  assign o_ctrl_oe = psp_on ? 3'h0 : ~ctrl_dir_ff;
  assign o_ctrl_pin = ctrl_latch_ff;

  // rd_start kept for symmetry of the edge pair
  wire unused_ok = rd_start & ^i_wb_adr[31:8] & ^i_wb_dat[31:8]
                   & ^i_wb_sel[3:1];
endmodule : sbp_port

/* sbp_monitor.sv */
module sbp_monitor
(
  // bus
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // pins
  input wire logic i_micro_mode,
  input wire logic [2:0] i_ctrl_pin,
  input wire logic [7:0] o_data_pin,
  input wire logic [7:0] o_data_oe,
  input wire logic [2:0] o_ctrl_oe,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] quiet_ff;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);
  // cycles since a strobe or mode change
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      quiet_ff <= 4'hf;
    else if ($changed(i_ctrl_pin) || $changed(i_micro_mode))
      quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hf)
      quiet_ff <= quiet_ff + 4'h1;
  end
  sequence req_s;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence ans_s;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  bus_answer_a: assert property (req_s |=> ans_s)
    else $error("bus answer wrong");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_stb))
    else $error("ack without request");
  rdata_high_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("read data upper bits set");
  irq_mode_a: assert property
    (!i_micro_mode && !$past(i_micro_mode) |-> !o_irq)
    else $error("irq outside internal mode");
  irq_cause_a: assert property
    ($rose(o_irq) |-> $past(o_wb_ack) || quiet_ff < 4'hc)
    else $error("irq rose without cause");
  drive_cause_a: assert property
    ($changed(o_data_oe) |-> $past(o_wb_ack) || quiet_ff < 4'hc)
    else $error("data drive without cause");
  ctrl_drive_a: assert property ($changed(o_ctrl_oe) |-> $past(o_wb_ack))
    else $error("control drive changed");
  latch_hold_a: assert property ($changed(o_data_pin) |-> $past(o_wb_ack))
    else $error("latch changed without write");
endmodule : sbp_monitor

bind sbp_port sbp_monitor i_sbp_monitor
(
  .i_ref_clk, .i_rst_b, .i_wb_cyc, .i_wb_stb, .o_wb_dat, .o_wb_ack,
  .i_micro_mode, .i_ctrl_pin, .o_data_pin, .o_data_oe, .o_ctrl_oe, .o_irq
);

/* sbp_host.sv */
module sbp_host
(
  // clock and bus level
  input wire logic i_ref_clk,
  input wire logic [7:0] i_bus,
  // driven lines
  output logic [7:0] o_d,
  output logic [2:0] o_c
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_d = 8'h00;
    o_c = 3'h7;
  end
  task automatic ext_wr(input logic [7:0] v);
    o_d <= v;
    repeat (4) @(posedge i_ref_clk);
    o_c <= 3'h1;
    repeat (8) @(posedge i_ref_clk);
    o_c <= 3'h7;
    repeat (4) @(posedge i_ref_clk);
    o_d <= ~v;
    repeat (4) @(posedge i_ref_clk);
  endtask : ext_wr
  task automatic ext_rd(output logic [7:0] q);
    o_c <= 3'h2;
    repeat (10) @(posedge i_ref_clk);
    q = i_bus;
    o_c <= 3'h7;
    repeat (8) @(posedge i_ref_clk);
  endtask : ext_rd
endmodule : sbp_host

/* sbp_port_test.sv */
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module sbp_port_test
  import sbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, we = 1'b0, micro = 1'b1, prio;
  logic [7:0] q, hq, oe, dpin, host_d;
  logic [2:0] cpin, c_oe, host_c;
  logic [31:0] adr = 32'h0, wd = 32'h0, rdat;
  logic [3:0] sel = 4'h1;
  logic ack, irq;
  wire logic [7:0] pin_d;
  wire logic [2:0] pin_c;
  int err_total = 0, tests_run = 0;
  assign pin_d = (oe & dpin) | (~oe & host_d);
  assign pin_c = (c_oe & cpin) | (~c_oe & host_c);
  sbp_port i_sbp_port
  (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wd),
    .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_micro_mode(micro),
    .i_data_pin(pin_d), .o_data_pin(dpin), .o_data_oe(oe),
    .i_ctrl_pin(pin_c), .o_ctrl_pin(cpin), .o_ctrl_oe(c_oe),
    .o_irq(irq), .o_irq_prio(prio)
  );
  sbp_host i_sbp_host
  (
    .i_ref_clk(clk), .i_bus(pin_d), .o_d(host_d), .o_c(host_c)
  );
  initial
    forever #4 clk = ~clk;
  task automatic end_sim();
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic wb(input logic w, input logic [7:0] a, d);
    int n = 0;
    req <= 1'b1;
    we <= w;
    adr <= {24'h000000, a};
    wd <= {24'h000000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1);
    q = rdat[7:0];
    req <= 1'b0;
    @(posedge clk);
    `CHK(n, 2)
  endtask : wb
  task automatic rc(input logic [7:0] a, e);
    wb(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask : rc
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rc(OFS_STATUS, 8'h00);
    rc(OFS_DATA_DIR, 8'hff);
    rc(OFS_IRQ_PRIO, 8'h7f);
    rc(OFS_IRQ_EN, 8'h00);
    rc(8'h3c, 8'h00);
    rc(OFS_CTRL_PINS, 8'h00);
    wb(1'b1, OFS_CTRL_LAT, 8'h05);
    rc(OFS_CTRL_LAT, 8'h05);
    `CHK(cpin, 3'h5)
    `CHK(prio, 1'b0)
    sel <= 4'h0;
    wb(1'b1, OFS_IRQ_PRIO, 8'h80);
    sel <= 4'h1;
    rc(OFS_IRQ_PRIO, 8'h7f);
    wb(1'b1, OFS_IRQ_PRIO, 8'hff);
    `CHK(prio, 1'b1)
    wb(1'b1, OFS_DATA_DIR, 8'h00);
    wb(1'b1, OFS_DATA_PINS, 8'h5a);
    `CHK({oe, dpin}, 16'hff5a)
    repeat (6) @(posedge clk);
    rc(OFS_DATA_PINS, 8'h5a);
    wb(1'b1, OFS_DATA_DIR, 8'hff);
    wb(1'b1, OFS_CTRL_DIR, 8'h07);
    wb(1'b1, OFS_ANALOG, 8'h07);
    rc(OFS_CTRL_PINS, 8'h07);
    wb(1'b1, OFS_STATUS, 8'hdf);
    rc(OFS_STATUS, 8'h10);
    `CHK(c_oe, 3'h0)
    wb(1'b1, OFS_IRQ_EN, 8'h80);
    i_sbp_host.ext_wr(8'ha5);
    rc(OFS_STATUS, 8'h90);
    `CHK(irq, 1'b1)
    rc(OFS_IRQ_FLAGS, 8'h80);
    i_sbp_host.ext_wr(8'h3c);
    rc(OFS_STATUS, 8'hb0);
    rc(OFS_DATA_PINS, 8'h3c);
    rc(OFS_STATUS, 8'h30);
    wb(1'b1, OFS_STATUS, 8'h10);
    rc(OFS_STATUS, 8'h10);
    wb(1'b1, OFS_IRQ_FLAGS, 8'h80);
    `CHK(irq, 1'b0)
    wb(1'b1, OFS_IRQ_EN, 8'h00);
    i_sbp_host.ext_wr(8'h81);
    `CHK(irq, 1'b0)
    rc(OFS_IRQ_FLAGS, 8'h80);
    rc(OFS_DATA_PINS, 8'h81);
    wb(1'b1, OFS_IRQ_FLAGS, 8'h80);
    wb(1'b1, OFS_DATA_PINS, 8'h96);
    rc(OFS_STATUS, 8'h50);
    i_sbp_host.ext_rd(hq);
    `CHK(hq, 8'h96)
    rc(OFS_STATUS, 8'h10);
    rc(OFS_IRQ_FLAGS, 8'h80);
    wb(1'b1, OFS_IRQ_FLAGS, 8'h80);
    micro <= 1'b0;
    i_sbp_host.ext_wr(8'h11);
    rc(OFS_STATUS, 8'h10);
    rc(OFS_IRQ_FLAGS, 8'h00);
    micro <= 1'b1;
    wb(1'b1, OFS_STATUS, 8'h00);
    i_sbp_host.ext_wr(8'h22);
    rc(OFS_STATUS, 8'h00);
    end_sim();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_sim();
  end
endmodule : sbp_port_test
